// >>> core/cotp_core.v
// option register, oscillator trim register and program counter
//
// Behaviour
// - option bits 7 and 6 low enable pin-change wake and pull-ups on bits 0,1,3.
// - option bit 5 picks external pin transitions (1) or instruction clock (0).
// - trim register holds fine field 7:4, speed-up bit 3, slow-down bit 2; 1:0 read zero.
// - with both trim bits set, the output behaves as speed-up only.
// - counter holds next address and increments each cycle unless loaded.
// - jump loads counter bits 8:0 from the instruction address field.
// - counter low byte reads and writes as the low latch register.
// - counter bit 9 takes the status page bit on every load.
// - call or latch write supplies counter bits 7:0 from instruction or data.
// - call or latch write forces counter bit 8 to zero.
// - move, add and bit-set into the low latch are computed loads.
`include "cotp_consts.vh"
module cotp_core (
  input  wire       mclk,             // instruction-cycle clock
  input  wire       rst_n,            // synchronous reset, active low
  input  wire       opt_load,         // option instruction, load option from w
  input  wire [7:0] w_data,           // working register value
  input  wire       reg_wr,           // data-memory write strobe
  input  wire       reg_rd,           // data-memory read strobe
  input  wire [7:0] reg_addr,         // data-memory address
  input  wire [7:0] reg_wdata,        // data-memory write data (result of move, add or bit set)
  output reg  [7:0] reg_rdata,        // data-memory read data
  input  wire       jump_op,          // executing a jump
  input  wire       call_op,          // executing a call
  input  wire [8:0] instr_addr,       // jump address field
  input  wire [7:0] instr_lit,        // call literal
  input  wire [7:0] status_reg,       // status register value
  input  wire       timer_ext_clock_pin, // external timer clock pin
  output reg  [9:0] pc,               // program counter
  output reg        pin_change_wake_en,// wake on change enabled
  output reg        pull_up_en,       // weak pull-ups enabled
  output reg        timer_tick,       // one-cycle timer count pulse
  output reg        prescaler_assign, // 1 watchdog, 0 timer
  output reg  [2:0] prescale_rate,    // rate field
  output reg  [3:0] trim_fine,        // fine calibration
  output reg        speed_up_trim,    // increase frequency
  output reg        slow_down_trim    // decrease frequency
);
  // ***********************************************
  // state
  // ***********************************************
  reg  [7:0] opt_r;
  reg  [7:0] trim_r;
  reg  [2:0] pin_sync_r;
  reg        pin_state_r;
  reg  [1:0] load_sel;
  wire [9:0] pc_nxt;
  wire       pin_settled;
  wire       pin_edge;
  wire       trim_wr;
  wire       pcl_wr;

  assign trim_wr = reg_wr && (reg_addr == `COTP_TRIM_ADDR);
  assign pcl_wr  = reg_wr && (reg_addr == `COTP_PCL_ADDR);

  // ***********************************************
  // option and trim registers
  // ***********************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      opt_r  <= `COTP_OPT_RESET;
      trim_r <= `COTP_TRIM_RESET;
    end else begin
      if (opt_load)
        opt_r <= w_data;
      if (trim_wr)
        trim_r <= reg_wdata & `COTP_TRIM_MASK;
    end
  end

  // ***********************************************
  // external timer pin
  // ***********************************************
  // the pin is asynchronous; a change only counts once stages two and three agree
  assign pin_settled = (pin_sync_r[1] == pin_sync_r[2]);
  assign pin_edge = pin_settled && (pin_sync_r[2] != pin_state_r) &&
                    (opt_r[`COTP_OPT_EDGE] ? !pin_sync_r[2] : pin_sync_r[2]);

  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_sync_r  <= 3'h0;
      pin_state_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], timer_ext_clock_pin};
      if (pin_settled)
        pin_state_r <= pin_sync_r[2];
    end
  end

  // ***********************************************
  // program counter
  // ***********************************************
  always @* begin
    if (pcl_wr)
      load_sel = `COTP_PC_COMP;
    else if (call_op)
      load_sel = `COTP_PC_CALL;
    else if (jump_op)
      load_sel = `COTP_PC_JUMP;
    else
      load_sel = `COTP_PC_INC;
  end

  cotp_pc_next u_pc_next (
    .pc_cur    (pc),
    .load_sel  (load_sel),
    .jump_addr (instr_addr),
    .low_data  (pcl_wr ? reg_wdata : instr_lit),
    .page_sel  (status_reg[`COTP_STATUS_PAGE]),
    .pc_nxt    (pc_nxt)
  );

  always @(posedge mclk) begin
    if (!rst_n)
      pc <= `COTP_PC_RESET;
    else
      pc <= pc_nxt;
  end

  // ***********************************************
  // outputs, all registered
  // ***********************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_change_wake_en <= 1'b0;
      pull_up_en         <= 1'b0;
      timer_tick         <= 1'b0;
      prescaler_assign   <= 1'b1;
      prescale_rate      <= 3'h7;
      trim_fine          <= 4'h7;
      speed_up_trim      <= 1'b0;
      slow_down_trim     <= 1'b0;
      reg_rdata          <= 8'h00;
    end else begin
      pin_change_wake_en <= !opt_r[`COTP_OPT_WAKE];
      pull_up_en         <= !opt_r[`COTP_OPT_PULL];
      // the internal source ticks every instruction cycle
      timer_tick         <= opt_r[`COTP_OPT_SRC] ? pin_edge : 1'b1;
      // division is applied by the downstream prescaler; only the field is passed on
      prescaler_assign   <= opt_r[`COTP_OPT_PSA];
      prescale_rate      <= opt_r[2:0];
      trim_fine          <= trim_r[7:4];
      speed_up_trim      <= trim_r[`COTP_TRIM_FST];
      slow_down_trim     <= trim_r[`COTP_TRIM_SLW] && !trim_r[`COTP_TRIM_FST];
      if (reg_rd && reg_addr == `COTP_TRIM_ADDR)
        reg_rdata <= trim_r;
      else if (reg_rd && reg_addr == `COTP_PCL_ADDR)
        reg_rdata <= pc[7:0];
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // cotp_core

// >>> core/cotp_consts.vh
// constants for the option, trim and program-counter block
`ifndef COTP_CONSTS_VH
`define COTP_CONSTS_VH
// ***********************************************
// register addresses and reset values
// ***********************************************
`define COTP_TRIM_ADDR      8'h8F
`define COTP_PCL_ADDR       8'h02
`define COTP_OPT_RESET      8'hFF
`define COTP_TRIM_RESET     8'h70
`define COTP_TRIM_MASK      8'hFC
`define COTP_PC_RESET       10'h3FF
// ***********************************************
// option field positions
// ***********************************************
`define COTP_OPT_WAKE       7
`define COTP_OPT_PULL       6
`define COTP_OPT_SRC        5
`define COTP_OPT_EDGE       4
`define COTP_OPT_PSA        3
// ***********************************************
// trim and status field positions
// ***********************************************
`define COTP_TRIM_FST       3
`define COTP_TRIM_SLW       2
`define COTP_STATUS_PAGE    5
// ***********************************************
// program-counter load selects
// ***********************************************
`define COTP_PC_INC         2'h0
`define COTP_PC_JUMP        2'h1
`define COTP_PC_CALL        2'h2
`define COTP_PC_COMP        2'h3
`endif

// >>> core/cotp_pc_next.v
// program-counter next-address selection
`include "cotp_consts.vh"
module cotp_pc_next (
  input  wire [9:0] pc_cur,     // current counter
  input  wire [1:0] load_sel,   // kind of load
  input  wire [8:0] jump_addr,  // nine-bit jump field
  input  wire [7:0] low_data,   // call literal or latch write data
  input  wire       page_sel,   // page bit from status
  output reg  [9:0] pc_nxt      // next counter value
);
  always @* begin
    case (load_sel)
      `COTP_PC_INC:  pc_nxt = pc_cur + 10'h001;
      `COTP_PC_JUMP: pc_nxt = {page_sel, jump_addr};
      `COTP_PC_CALL: pc_nxt = {page_sel, 1'b0, low_data};
      `COTP_PC_COMP: pc_nxt = {page_sel, 1'b0, low_data};
      default:       pc_nxt = pc_cur + 10'h001;
    endcase
  end
endmodule // cotp_pc_next

// >>> tb/cotp_core_assertions.sv
// assertion checker bound to the option, trim and counter block
`include "cotp_consts.vh"
module cotp_core_assertions (
  input wire       mclk, rst_n, opt_load, reg_wr, jump_op, call_op,    // controls
  input wire [7:0] w_data, reg_addr, reg_wdata, instr_lit, status_reg, // data
  input wire [8:0] instr_addr,                                         // jump field
  input wire [9:0] pc,                                                 // counter
  input wire       pull_up_en, pin_change_wake_en, timer_tick,         // option outputs
  input wire       prescaler_assign,                                   // prescaler owner
  input wire [2:0] prescale_rate,                                      // rate
  input wire [3:0] trim_fine,                                          // fine trim
  input wire       speed_up_trim, slow_down_trim                       // coarse trim
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ld  = reg_wr && reg_addr == `COTP_PCL_ADDR;
  wire tw  = reg_wr && reg_addr == `COTP_TRIM_ADDR;
  wire pg  = status_reg[`COTP_STATUS_PAGE];
  wire slw = reg_wdata[`COTP_TRIM_SLW] && !reg_wdata[`COTP_TRIM_FST];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // derived outputs lag their register by one cycle, so checks land two edges on
  sequence s_opt; opt_load ##1 1; endsequence
  sequence s_trim; tw ##1 1; endsequence
  a_pc_advance: assert property (!ld && !call_op && !jump_op |=> pc == $past(pc) + 10'h001)
    else $error("pc step");
  a_jump_load: assert property (jump_op && !call_op && !ld |=> pc == {$past(pg), $past(instr_addr)})
    else $error("jump load");
  a_call_load: assert property (call_op && !ld |=> pc == {$past(pg), 1'h0, $past(instr_lit)})
    else $error("call load");
  a_latch_load: assert property (ld |=> pc == {$past(pg), 1'h0, $past(reg_wdata)})
    else $error("latch load");
  a_pin_enables: assert property (s_opt |=> {pin_change_wake_en, pull_up_en} == ~$past(w_data[7:6], 2))
    else $error("pin enables");
  a_prescale_set: assert property (s_opt |=> {prescaler_assign, prescale_rate} == $past(w_data[3:0], 2))
    else $error("prescaler");
  a_internal_tick: assert property (opt_load && !w_data[5] ##1 !opt_load [*2] |=> timer_tick)
    else $error("tick");
  a_trim_fields: assert property (s_trim |=> {trim_fine, speed_up_trim} == $past(reg_wdata[7:3], 2))
    else $error("trim");
  a_trim_precedence: assert property (s_trim |=> slow_down_trim == $past(slw, 2))
    else $error("trim both");
endmodule // cotp_core_assertions
bind cotp_core cotp_core_assertions i_chk (.*);

// >>> tb/cotp_core_tb.sv
// self-checking bench for the option, trim and program-counter block
`include "cotp_consts.vh"
module cotp_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, opt_load, reg_wr, reg_rd, jump_op, call_op, timer_ext_clock_pin;
  logic [7:0]  w_data, reg_addr, reg_wdata, instr_lit, status_reg;
  logic [8:0]  instr_addr;
  wire  [7:0]  reg_rdata;
  wire  [9:0]  pc;
  wire  [3:0]  trim_fine;
  wire  [2:0]  prescale_rate;
  wire         pin_change_wake_en, pull_up_en, timer_tick, prescaler_assign, speed_up_trim, slow_down_trim;
  int          err_total, samples_checked, n;
  // {latch write, call, jump}, page, field, expected pc; latch data is the inverted field
  logic [22:0] rows [9] = '{{3'h0, 1'h0, 9'h000, 10'h000}, {3'h1, 1'h0, 9'h1A5, 10'h1A5}, {3'h0, 1'h0, 9'h000, 10'h1A6},
    {3'h2, 1'h1, 9'h134, 10'h234}, {3'h6, 1'h1, 9'h155, 10'h2AA}, {3'h3, 1'h0, 9'h1C3, 10'h0C3},
    {3'h1, 1'h1, 9'h1FF, 10'h3FF}, {3'h0, 1'h0, 9'h000, 10'h000}, {3'h4, 1'h0, 9'h100, 10'h0FF}};
  logic [7:0]  opts [2] = '{8'hB5, 8'h4A};
  logic [23:0] trims [3] = '{24'h8FFFFF, 24'h8F5656, 24'h8E0056};
  cotp_core i_dut (.*);
  task step; @(posedge mclk); #5; endtask
  task chk(input string nm, input logic [9:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task opt_wr(input logic [7:0] v);
    opt_load = 1'h1;
    w_data = v;
    step;
    opt_load = 1'h0;
    repeat (3) step;
  endtask
  task pin_ticks(input logic v, input logic [9:0] e);
    timer_ext_clock_pin = v;
    n = 0;
    repeat (10) begin
      step;
      n += (timer_tick === 1'h1);
    end
    chk("ticks", e, n[9:0]);
  endtask
  task trim_wr(input logic [7:0] a, d, e);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_wr = 1'h0;
    reg_rd = 1'h1;
    reg_addr = `COTP_TRIM_ADDR;
    step;
    reg_rd = 1'h0;
    chk("trim read", e & `COTP_TRIM_MASK, reg_rdata);
    step;
    chk("trim out", {e[7:3], e[2] & ~e[3]}, {trim_fine, speed_up_trim, slow_down_trim});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // generous bound; the whole sequence needs under a hundred cycles
  initial begin
    repeat (2000) @(posedge mclk);
    err_total++;
    end_of_test;
  end
  initial begin
    {opt_load, reg_wr, reg_rd, jump_op, call_op, timer_ext_clock_pin, rst_n} = '0;
    {w_data, reg_wdata, instr_lit, status_reg, instr_addr} = '0;
    reg_addr = `COTP_PCL_ADDR;
    for (int r = 0; r < 2; r++) begin
      repeat (r ? 2 : 16) step;
      chk("pc reset", `COTP_PC_RESET, pc);
      chk("trim reset", {2'h0, `COTP_TRIM_RESET}, {trim_fine, speed_up_trim, slow_down_trim, 2'h0});
      chk("opt reset", 10'h00F, {pin_change_wake_en, pull_up_en, prescaler_assign, prescale_rate});
      rst_n = 1'h1;
      $display("test reset done");
      if (r)
        break;
      for (int i = 0; i < 9; i++) begin
        {reg_wr, call_op, jump_op} = rows[i][22:20];
        status_reg[`COTP_STATUS_PAGE] = rows[i][19];
        instr_addr = rows[i][18:10];
        instr_lit = rows[i][17:10];
        reg_wdata = ~rows[i][17:10];
        step;
        chk("pc", rows[i][9:0], pc);
      end
      {reg_wr, call_op, jump_op} = '0;
      // the latch read returns the counter value from before this edge
      reg_rd = 1'h1;
      step;
      reg_rd = 1'h0;
      chk("pcl read", 10'h0FF, reg_rdata);
      foreach (opts[j]) begin
        opt_wr(opts[j]);
        chk("option", {~opts[j][7:6], opts[j][3:0]}, {pin_change_wake_en, pull_up_en, prescaler_assign, prescale_rate});
      end
      chk("tick internal", 10'h001, timer_tick);
      // rising-edge mode first, then falling-edge mode
      for (int e = 0; e < 2; e++) begin
        opt_wr(e ? 8'h30 : 8'h20);
        pin_ticks(1'h1, e == 0);
        pin_ticks(1'h0, e == 1);
      end
      foreach (trims[k])
        trim_wr(trims[k][23:16], trims[k][15:8], trims[k][7:0]);
      $display("test pc, option, pin and trim done");
      rst_n = 1'h0;
    end
    end_of_test;
  end
endmodule // cotp_core_tb
